// >>> teasi_defs.svh
// constants for the alarm status and interrupt block
`ifndef TEASI_DEFS_SVH
`define TEASI_DEFS_SVH
`define TEASI_OFS_SR_RX 8'h18
`define TEASI_OFS_MSK_RX 8'h19
`define TEASI_OFS_SR_LC 8'h1a
`define TEASI_OFS_MSK_LC 8'h1b
`define TEASI_OFS_SR_FT 8'h1c
`define TEASI_OFS_MSK_FT 8'h1d
`define TEASI_OFS_CFG 8'h1e
`define TEASI_RST8 8'h00
`define TEASI_RST24 24'h000000
`define TEASI_CFG_E1 0
`define TEASI_CFG_THR2048 1
`define TEASI_CFG_PINSEL 2
`define TEASI_CFG_CRC4 3
`define TEASI_CFG_MASK 8'h0f
`define TEASI_ZEROS_T1 12'd192
`define TEASI_ZEROS_E1 12'd255
`define TEASI_ZEROS_E1_LONG 12'd2048
`define TEASI_WIN_LAST 8'd254
`define TEASI_ONES_MIN 8'd32
`define TEASI_CLK_MHZ 250
`define TEASI_CHAN_E1_NS 3906
`define TEASI_CHAN_T1_NS 5181
`define TEASI_CHAN_E1_CYC \
  (((`TEASI_CHAN_E1_NS * `TEASI_CLK_MHZ) + 999) / 1000)
`define TEASI_CHAN_T1_CYC \
  (((`TEASI_CHAN_T1_NS * `TEASI_CLK_MHZ) + 999) / 1000)
`define TEASI_DMA_BIT 2
`define TEASI_MF_FIRST 4'h0
`define TEASI_MF_LAST 4'hf
`define TEASI_AO_SAT 4'd3
`endif

// >>> teasi_pkg.sv
// types shared by the alarm status and interrupt block
package teasi_pkg;
  typedef struct packed {
    logic in_sync;
    logic unframed_ones;
    logic yellow;
    logic remote_alarm;
    logic v5_link;
    logic loop_up;
    logic loop_down;
    logic spare;
    logic ais_ci;
    logic rx_af;
    logic rx_crc_mf;
    logic rx_mf;
    logic tx_af;
    logic tx_mf;
    logic ts16_vld;
    logic [3:0] ts16_frame;
    logic [7:0] ts16_byte;
  } teasi_ind_t;
endpackage

// >>> teasi_clk_watch.sv
// line clock synchroniser with transition watchdog
`timescale 1ns/100ps
`include "teasi_defs.svh"
module teasi_clk_watch (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched pin
  input wire logic pin_in,
  input wire logic [11:0] limit,
  // results
  output logic rise,
  output logic lost
);
  logic s1_r, s2_r, s3_r, stab_r, stab_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic rise_r, rise_nxt, lost_r, lost_nxt;

  always_comb
  begin
    stab_nxt = (s2_r == s3_r) ? s3_r : stab_r;
    rise_nxt = stab_nxt & ~stab_r;
    if (stab_nxt != stab_r)
      cnt_nxt = 12'h000;
    else if (cnt_r >= limit)
      cnt_nxt = cnt_r;
    else
      cnt_nxt = cnt_r + 12'h001;
    lost_nxt = (cnt_nxt >= limit);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      stab_r <= 1'b0;
      cnt_r <= 12'h000;
      rise_r <= 1'b0;
      lost_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      stab_r <= stab_nxt;
      cnt_r <= cnt_nxt;
      rise_r <= rise_nxt;
      lost_r <= lost_nxt;
    end
  end

  assign rise = rise_r;
  assign lost = lost_r;
endmodule

// >>> teasi_top.sv
// receive alarm, clock loss and frame timing status with interrupt
`timescale 1ns/100ps
`include "teasi_defs.svh"
module teasi_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // line pins
  input wire logic rx_line_pos_in,
  input wire logic rx_line_neg_in,
  input wire logic rx_line_clock_in,
  input wire logic tx_line_clock_in,
  // framer indications
  input wire teasi_pkg::teasi_ind_t ind,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // outputs
  output logic irq,
  output logic shared_alarm_pin
);
  // line data synchroniser, three stages
  logic [1:0] d1_r, d2_r, d3_r, dst_r, dst_nxt;
  logic [1:0] ck_rise, ck_lost;
  logic [11:0] chan_lim;
  logic e1, t1;

  // carrier detector state
  logic [11:0] zcnt_r, zcnt_nxt, zthr;
  logic [7:0] win_r, win_nxt, ones_r, ones_nxt;
  logic carrier_r, carrier_nxt;

  // timeslot 16 state
  logic [1:0] dma_r, dma_nxt;
  logic az_r, az_nxt;
  logic [3:0] zc_r, zc_nxt, zb;
  logic [4:0] zsum;
  logic az_ev, ao_ev;

  // status state
  logic [7:0] cfg_r, cfg_nxt;
  logic [23:0] stat_r, stat_nxt, pend_r, pend_nxt;
  logic [23:0] msk_r, msk_nxt, set_v, pset_v, clr_v;
  logic [3:0] cond_rx, crx_q_r, rise_rx, fall_rx;
  logic [7:0] cond_lc, clc_q_r, rise_lc, fall_lc, ev_ft;
  logic [7:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt, pin_r, pin_nxt;

  assign e1 = cfg_r[`TEASI_CFG_E1];
  assign t1 = ~e1;
  assign chan_lim = e1 ? 12'(`TEASI_CHAN_E1_CYC)
                       : 12'(`TEASI_CHAN_T1_CYC);

  // index 0 watches the receive clock, index 1 the transmit clock
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_watch
      teasi_clk_watch u_watch (
        .clk(clk),
        .rst(rst),
        .pin_in(gi == 0 ? rx_line_clock_in : tx_line_clock_in),
        .limit(chan_lim),
        .rise(ck_rise[gi]),
        .lost(ck_lost[gi])
      );
    end
  endgenerate

  // data follows the same depth as the clock path, three stages and a stable stage
  always_comb
  begin
    for (int i = 0; i < 2; i++)
      dst_nxt[i] = (d2_r[i] == d3_r[i]) ? d3_r[i] : dst_r[i];
    zthr = t1 ? `TEASI_ZEROS_T1 :
           (cfg_r[`TEASI_CFG_THR2048] ? `TEASI_ZEROS_E1_LONG
                                      : `TEASI_ZEROS_E1);
    zcnt_nxt = zcnt_r;
    win_nxt = win_r;
    ones_nxt = ones_r;
    carrier_nxt = carrier_r;
    if (ck_rise[0])
    begin
      if (dst_r == 2'b00)
      begin
        if (zcnt_r < zthr)
          zcnt_nxt = zcnt_r + 12'h001;
      end
      else
      begin
        zcnt_nxt = 12'h000;
        if (ones_r < `TEASI_ONES_MIN)
          ones_nxt = ones_r + 8'h01;
      end
      if (win_r == `TEASI_WIN_LAST)
      begin
        // recovery needs ones density, not a single mark
        if (ones_nxt >= `TEASI_ONES_MIN)
          carrier_nxt = 1'b0;
        win_nxt = 8'h00;
        ones_nxt = 8'h00;
      end
      else
        win_nxt = win_r + 8'h01;
      if (zcnt_nxt >= zthr)
        carrier_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      d1_r <= 2'b00;
      d2_r <= 2'b00;
      d3_r <= 2'b00;
      dst_r <= 2'b00;
      zcnt_r <= 12'h000;
      win_r <= 8'h00;
      ones_r <= 8'h00;
      carrier_r <= 1'b0;
    end
    else
    begin
      d1_r <= {rx_line_neg_in, rx_line_pos_in};
      d2_r <= d1_r;
      d3_r <= d2_r;
      dst_r <= dst_nxt;
      zcnt_r <= zcnt_nxt;
      win_r <= win_nxt;
      ones_r <= ones_nxt;
      carrier_r <= carrier_nxt;
    end
  end

  // timeslot 16 watchers, frame index from the framer
  always_comb
  begin
    dma_nxt = dma_r;
    az_nxt = az_r;
    zc_nxt = zc_r;
    az_ev = 1'b0;
    ao_ev = 1'b0;
    zb = 4'(8 - $countones(ind.ts16_byte));
    zsum = (ind.ts16_frame == `TEASI_MF_FIRST)
           ? {1'b0, zb} : ({1'b0, zc_r} + {1'b0, zb});
    if (ind.ts16_vld && e1)
    begin
      if (ind.ts16_frame == `TEASI_MF_FIRST)
      begin
        dma_nxt = {dma_r[0], ind.ts16_byte[`TEASI_DMA_BIT]};
        az_nxt = (ind.ts16_byte == 8'h00);
      end
      else
        az_nxt = az_r & (ind.ts16_byte == 8'h00);
      zc_nxt = (zsum >= {1'b0, `TEASI_AO_SAT}) ? `TEASI_AO_SAT
                                               : zsum[3:0];
      if (ind.ts16_frame == `TEASI_MF_LAST)
      begin
        az_ev = az_nxt;
        ao_ev = (zc_nxt < `TEASI_AO_SAT);
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dma_r <= 2'b00;
      az_r <= 1'b0;
      zc_r <= 4'h0;
    end
    else
    begin
      dma_r <= dma_nxt;
      az_r <= az_nxt;
      zc_r <= zc_nxt;
    end
  end

  // status, pending and mask, three registers side by side
  always_comb
  begin
    cond_rx = {ind.yellow & t1,
               ind.unframed_ones,
               carrier_r,
               ~ind.in_sync};
    cond_lc = {ind.spare & t1, ind.loop_down & t1,
               ind.loop_up & t1,
               ck_lost[1],
               ck_lost[0],
               ind.v5_link & e1,
               (&dma_r) & e1,
               ind.remote_alarm & e1};
    ev_ft = {ind.ais_ci & t1,
             ao_ev, az_ev,
             ind.tx_mf,
             ind.tx_af & e1,
             ind.rx_mf,
             e1 & (cfg_r[`TEASI_CFG_CRC4] ? ind.rx_crc_mf
                                          : ind.rx_mf),
             ind.rx_af & e1};
    rise_rx = cond_rx & ~crx_q_r;
    fall_rx = crx_q_r & ~cond_rx;
    rise_lc = cond_lc & ~clc_q_r;
    fall_lc = clc_q_r & ~cond_lc;
    set_v = {ev_ft, cond_lc | fall_lc, fall_rx, cond_rx};
    pset_v = {ev_ft, rise_lc | fall_lc,
              fall_rx, rise_rx};
    clr_v = {{8{rd && addr == `TEASI_OFS_SR_FT}},
             {8{rd && addr == `TEASI_OFS_SR_LC}},
             {8{rd && addr == `TEASI_OFS_SR_RX}}};
    // a flag raised in the reading cycle survives the read
    stat_nxt = set_v | (stat_r & ~clr_v);
    pend_nxt = pset_v | (pend_r & ~clr_v);
    msk_nxt = msk_r;
    cfg_nxt = cfg_r;
    if (wr)
    begin
      case (addr)
        `TEASI_OFS_MSK_RX: msk_nxt[7:0] = wdata;
        `TEASI_OFS_MSK_LC: msk_nxt[15:8] = wdata;
        `TEASI_OFS_MSK_FT: msk_nxt[23:16] = wdata;
        `TEASI_OFS_CFG: cfg_nxt = wdata & `TEASI_CFG_MASK;
        default: cfg_nxt = cfg_r;
      endcase
    end
    rdata_nxt = `TEASI_RST8;
    if (rd)
    begin
      case (addr)
        `TEASI_OFS_SR_RX: rdata_nxt = stat_r[7:0];
        `TEASI_OFS_MSK_RX: rdata_nxt = msk_r[7:0];
        `TEASI_OFS_SR_LC: rdata_nxt = stat_r[15:8];
        `TEASI_OFS_MSK_LC: rdata_nxt = msk_r[15:8];
        `TEASI_OFS_SR_FT: rdata_nxt = stat_r[23:16];
        `TEASI_OFS_MSK_FT: rdata_nxt = msk_r[23:16];
        `TEASI_OFS_CFG: rdata_nxt = cfg_r;
        default: rdata_nxt = `TEASI_RST8;
      endcase
    end
    // one cycle of latency keeps the pin glitch free
    irq_nxt = |(pend_r & msk_r);
    pin_nxt = cfg_r[`TEASI_CFG_PINSEL] ? ck_lost[1]
                                       : ~ind.in_sync;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      crx_q_r <= 4'h0;
      clc_q_r <= `TEASI_RST8;
      stat_r <= `TEASI_RST24;
      pend_r <= `TEASI_RST24;
      msk_r <= `TEASI_RST24;
      cfg_r <= `TEASI_RST8;
      rdata_r <= `TEASI_RST8;
      irq_r <= 1'b0;
      pin_r <= 1'b0;
    end
    else
    begin
      crx_q_r <= cond_rx;
      clc_q_r <= cond_lc;
      stat_r <= stat_nxt;
      pend_r <= pend_nxt;
      msk_r <= msk_nxt;
      cfg_r <= cfg_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      pin_r <= pin_nxt;
    end
  end

  assign rdata = rdata_r;
  assign irq = irq_r;
  assign shared_alarm_pin = pin_r;
endmodule

// >>> teasi_line_model.sv
// line side model: bipolar receive data and line clocks
`timescale 1ns/100ps
module teasi_line_model (
  // clock and controls
  input wire logic clk,
  input wire logic run,
  input wire logic ones,
  // line pins
  output logic rck,
  output logic tck,
  output logic pos,
  output logic neg
);
  logic [2:0] div_r = 3'h0;
  logic clk_r = 1'b0;
  logic par_r = 1'b0;
  logic one_r = 1'b1;
  // clocks stand still while stopped, as on a failed line
  always @(posedge clk)
    if (run)
    begin
      div_r <= div_r + 3'h1;
      if (div_r == 3'h7)
        clk_r <= ~clk_r;
      // new bit on the falling line clock edge
      if (div_r == 3'h7 && clk_r)
      begin
        one_r <= ones;
        par_r <= ~par_r;
      end
    end
  assign rck = clk_r;
  assign tck = clk_r;
  // the rail alternates every bit, a zero leaves both low
  assign pos = one_r & par_r;
  assign neg = one_r & ~par_r;
endmodule

// >>> teasi_top_asserts.sv
// port checker for the alarm status and interrupt block
`timescale 1ns/100ps
module teasi_top_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // line pins
  input wire logic rx_line_pos_in,
  input wire logic rx_line_neg_in,
  input wire logic rx_line_clock_in,
  input wire logic tx_line_clock_in,
  // framer and register port
  input wire teasi_pkg::teasi_ind_t ind,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // outputs
  input wire logic irq,
  input wire logic shared_alarm_pin
);
  logic [7:0] mft_r;
  logic [1:0] nz_r;
  logic sel_r;
  logic quiet;
  // no event pulse and no timeslot 16 strobe
  assign quiet = ind[18:12] == 7'h00;
  // host write shadows, design registers are hidden
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      mft_r <= 8'h00;
      nz_r <= 2'b00;
      sel_r <= 1'b0;
    end
    else if (wr)
    begin
      if (addr == 8'h1d)
        mft_r <= wdata;
      if (addr == 8'h1e)
        sel_r <= wdata[2];
      if (addr == 8'h19)
        nz_r[0] <= |wdata;
      if (addr == 8'h1b)
        nz_r[1] <= |wdata;
    end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ft_q;
    rd && addr == 8'h1c && quiet;
  endsequence
  sequence s_regain;
    !ind.in_sync [*2] ##1 (ind.in_sync && !rd) [*4];
  endsequence
  chk_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not idle");
  chk_mask_back: assert property ((wr && addr == 8'h19) ##1
    (rd && addr == 8'h19) |=> rdata == $past(wdata, 2))
    else $error("mask read back wrong");
  chk_irq_masked: assert property
    ((nz_r == 2'b00 && mft_r == 8'h00) [*2] |-> !irq)
    else $error("irq with all masks clear");
  chk_irq_fall: assert property
    ($fell(irq) |-> $past(rd | wr) || $past(rd | wr, 2))
    else $error("irq dropped with no host access");
  chk_event_irq: assert property
    ((ind.rx_mf && mft_r[2] && !rd && !wr) ##1 !rd |-> ##1 irq)
    else $error("unmasked event gave no irq");
  chk_tx_mf_seen: assert property
    ((ind.tx_mf && !rd) ##1 !rd ##1 (rd && addr == 8'h1c) |=> rdata[4])
    else $error("tx multiframe event lost");
  chk_read_clears: assert property
    (s_ft_q ##1 quiet ##1 s_ft_q |=> rdata == 8'h00)
    else $error("status not cleared by read");
  chk_regain_seen: assert property
    (s_regain ##1 (rd && addr == 8'h18) |=> rdata[4])
    else $error("sync regained event lost");
  chk_pin_sync: assert property
    ((!sel_r && !ind.in_sync) [*4] |-> shared_alarm_pin)
    else $error("shared pin not showing sync loss");
endmodule
bind teasi_top teasi_top_chk u_chk (.clk(clk), .rst(rst),
  .rx_line_pos_in(rx_line_pos_in), .rx_line_neg_in(rx_line_neg_in),
  .rx_line_clock_in(rx_line_clock_in), .tx_line_clock_in(tx_line_clock_in),
  .ind(ind), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .irq(irq), .shared_alarm_pin(shared_alarm_pin));

// >>> t1e1_alarm_status_irq_test.sv
// self-checking bench for the alarm status and interrupt block
`timescale 1ns/100ps
module t1e1_alarm_status_irq_test;
  typedef struct packed {
    logic [7:0] wa;
    logic [7:0] d;
    logic [7:0] ra;
    logic [7:0] e;
  } teasi_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr, rd, irq, pin, run, ones, pos, neg, rck, tck;
  logic [7:0] addr, wdata, rdata;
  teasi_pkg::teasi_ind_t ind;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  // write one place, read another: reset values, refusals, read back
  teasi_row_t rows [14] = '{32'h1fff1900, 32'h1fff1b00, 32'h1fff1d00,
    32'h1fff1c00, 32'h1fff1a00, 32'h19ff19ff, 32'h19001900, 32'h1ba51ba5,
    32'h1b001b00, 32'h1d5a1d5a, 32'h1d001d00, 32'h1cff1c00, 32'h1aff1a00,
    32'h18ff1f00};
  teasi_top DUT (.clk(clk), .rst(rst), .rx_line_pos_in(pos),
    .rx_line_neg_in(neg), .rx_line_clock_in(rck), .tx_line_clock_in(tck),
    .ind(ind), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq(irq), .shared_alarm_pin(pin));
  teasi_line_model u_line (.clk(clk), .run(run), .ones(ones), .rck(rck),
    .tck(tck), .pos(pos), .neg(neg));
  always #2 clk = ~clk;
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // whole run is near 13200 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // write then read with no gap
  task automatic acc(input teasi_row_t r);
    wrt(r.wa, r.d);
    {rd, addr} <= {1'b1, r.ra};
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, r.e);
  endtask
  // one cycle pulses: ais_ci rx_af rx_crc_mf rx_mf tx_af tx_mf
  task automatic ev(input logic [5:0] m);
    @(posedge clk) ind[18:13] <= m;
    @(posedge clk) ind[18:13] <= 6'h00;
  endtask
  task automatic mframe(input logic [7:0] b);
    for (int f = 0; f < 16; f++)
    begin
      @(posedge clk) ind[12:0] <= {1'b1, f[3:0], b};
      @(posedge clk) ind.ts16_vld <= 1'b0;
    end
  endtask
  initial
  begin
    {wr, rd, addr, wdata, ind} = '0;
    {run, ones} = 2'b11;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) acc(rows[i]);
    rdc(8'h18, 8'h01);
    chk({7'h0, pin}, 8'h01);
    @(posedge clk) ind.in_sync <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(8'h18, 8'h11);
    rdc(8'h18, 8'h00);
    @(posedge clk) {ind[25:23], ind.loop_up} <= 4'hf;
    repeat (3) @(posedge clk);
    rdc(8'h18, 8'h0c);
    rdc(8'h1a, 8'h20);
    @(posedge clk) {ind[25:23], ind.loop_up} <= 4'h0;
    repeat (3) @(posedge clk);
    rdc(8'h18, 8'hcc);
    rdc(8'h1a, 8'h20);
    wrt(8'h1e, 8'h09);
    wrt(8'h1d, 8'h04);
    ev(6'h1f);
    @(posedge clk);
    #1 chk({7'h0, irq}, 8'h01);
    rdc(8'h1c, 8'h1f);
    rdc(8'h1c, 8'h00);
    // irq drops one cycle after the clearing read
    chk({7'h0, irq}, 8'h00);
    wrt(8'h1e, 8'h01);
    ev(6'h04);
    rdc(8'h1c, 8'h06);
    wrt(8'h1e, 8'h00);
    ev(6'h3f);
    rdc(8'h1c, 8'h94);
    wrt(8'h1d, 8'h00);
    wrt(8'h1e, 8'h09);
    mframe(8'h00);
    rdc(8'h1c, 8'h20);
    mframe(8'hff);
    rdc(8'h1c, 8'h40);
    mframe(8'hff);
    rdc(8'h1a, 8'h02);
    // carrier: 16 cycles a bit, 192 zeros in T1
    wrt(8'h1e, 8'h00);
    wrt(8'h19, 8'h02);
    // leaving E1 ends the distant alarm, latched until read
    rdc(8'h1a, 8'h02);
    ones <= 1'b0;
    repeat (180 * 16) @(posedge clk);
    rdc(8'h18, 8'h00);
    repeat (20 * 16) @(posedge clk);
    chk({7'h0, irq}, 8'h01);
    rdc(8'h18, 8'h02);
    @(posedge clk) ones <= 1'b1;
    #1 chk({7'h0, irq}, 8'h00);
    repeat (520 * 16) @(posedge clk);
    rdc(8'h18, 8'h22);
    wrt(8'h19, 8'h00);
    wrt(8'h1e, 8'h04);
    wrt(8'h1b, 8'h18);
    run <= 1'b0;
    // t1 channel time is 1296 cycles, plus synchroniser depth
    repeat (1400) @(posedge clk);
    chk({6'h0, pin, irq}, 8'h03);
    rdc(8'h1a, 8'h18);
    @(posedge clk) run <= 1'b1;
    repeat (40) @(posedge clk);
    chk({7'h0, irq}, 8'h01);
    wrt(8'h1b, 8'h00);
    tally_and_finish();
  end
endmodule
